// ---- spi_read_pkg.sv ----
package spi_read_pkg;

    // Output word and counter sizing
    localparam int WORD_W = 22;
    localparam int CNT_W = 6;
    localparam int POS_W = 9;
    localparam int LANES_MAX = 4;

    // Reset values of the two control registers
    localparam logic [7:0] IN_CTRL_RESET = 8'h00;
    localparam logic [7:0] OUT_CTRL_RESET = 8'h00;

    // Field positions inside the control registers
    localparam int CAP_SEL_LSB = 0;
    localparam int OUT_SEL_LSB = 0;
    localparam int LANE_W_LSB = 2;

    // Output control values that keep the daisy chain alive
    localparam logic [7:0] DAISY_CTRL_STD = 8'h00;
    localparam logic [7:0] DAISY_CTRL_EARLY = 8'h01;

    // Capture protocol: clock level at frame start and capture edge
    typedef enum logic [1:0] {
        CAP_LOW_RISE = 2'h0,
        CAP_LOW_FALL = 2'h1,
        CAP_HIGH_FALL = 2'h2,
        CAP_HIGH_RISE = 2'h3
    } cap_mode_t;

    // Output protocol selector codes
    localparam logic [1:0] OUT_STANDARD = 2'h0;
    localparam logic [1:0] OUT_EARLY = 2'h1;
    localparam logic [1:0] OUT_SRC = 2'h3;

    // Lane width codes
    localparam logic [1:0] LANE_DUAL = 2'h2;
    localparam logic [1:0] LANE_QUAD = 2'h3;

    // Lane counts per width
    localparam logic [2:0] LANES_ONE = 3'h1;
    localparam logic [2:0] LANES_TWO = 3'h2;
    localparam logic [2:0] LANES_FOUR = 3'h4;

    // Saturation value of the launch counters
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

endpackage : spi_read_pkg

// ---- adc_serial_read_port.sv ----
module adc_serial_read_port (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic [7:0] i_input_control_reg,
    input wire logic [7:0] i_output_control_reg,
    input wire logic [spi_read_pkg::WORD_W-1:0] i_data_word,
    input wire logic i_data_valid,
    output logic o_out_lane0,
    output logic o_out_lane1,
    output logic o_out_lane2,
    output logic o_out_lane3,
    output logic o_strobe_out_pin,
    output logic o_frame_busy
);
    import spi_read_pkg::*;

    // Lane count for a width code; one lane for anything not widened
    function automatic logic [2:0] lanes_of(input logic [1:0] code);
        logic [2:0] n;
        n = LANES_ONE;
        if (code == LANE_DUAL) begin
            n = LANES_TWO;
        end else if (code == LANE_QUAD) begin
            n = LANES_FOUR;
        end
        return n;
    endfunction : lanes_of

    // System domain state
    logic cs_meta; // First synchroniser stage, read only by cs_sync
    logic cs_sync; // Chip select seen in the system domain
    logic [7:0] input_control_reg; // Frozen copy for the link logic
    logic [7:0] output_control_reg; // Frozen copy for the link logic
    logic [WORD_W-1:0] frame_word; // Word shifted out in the next frame

    // Link domain state, cleared while chip select is high
    logic [CNT_W-1:0] rise_cnt; // Rising edges seen in this frame
    logic [CNT_W-1:0] fall_cnt; // Falling edges seen in this frame
    logic [WORD_W-1:0] rise_chain; // Input bits taken on rising edges
    logic [WORD_W-1:0] fall_chain; // Input bits taken on falling edges

    // Decoded configuration
    wire frame_sys = ~cs_sync;
    wire [1:0] cap_sel = input_control_reg[CAP_SEL_LSB +: 2];
    wire [1:0] output_protocol_sel = output_control_reg[OUT_SEL_LSB +: 2];
    wire [1:0] output_lane_width = output_control_reg[LANE_W_LSB +: 2];
    wire [2:0] lanes = lanes_of(output_lane_width);
    wire source_sync_mode = (output_protocol_sel == OUT_SRC);
    wire early_sel_ok = (cap_sel == CAP_LOW_RISE) || (cap_sel == CAP_HIGH_FALL);
    wire early_launch = (output_protocol_sel == OUT_EARLY) && early_sel_ok;
    wire daisy_en = (output_control_reg == DAISY_CTRL_STD) || (output_control_reg == DAISY_CTRL_EARLY);
    wire capture_on_rise = (cap_sel == CAP_LOW_RISE) || (cap_sel == CAP_HIGH_RISE);
    wire daisy_bit = capture_on_rise ? rise_chain[WORD_W-1] : fall_chain[WORD_W-1];
    wire [CNT_W-1:0] rise_m1 = rise_cnt - 6'h01;
    wire [CNT_W-1:0] fall_m1 = fall_cnt - 6'h01;

    // Launch index and whether any bit has been launched yet
    logic [CNT_W-1:0] launch_idx;
    logic idx_valid;
    logic [3:0] lane_bit;

    // Chip select synchroniser; idle high so reset sees no frame
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
        end else begin
            cs_meta <= i_cs_n;
            cs_sync <= cs_meta;
        end
    end

    // Configuration follows the inputs only between frames, so the link
    // logic reads it as quasi-static without a per-bit crossing
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            input_control_reg <= IN_CTRL_RESET;
            output_control_reg <= OUT_CTRL_RESET;
        end else if (!frame_sys) begin
            input_control_reg <= i_input_control_reg;
            output_control_reg <= i_output_control_reg;
        end
    end

    // Word taken between frames and frozen while chip select is low;
    // the freeze is the load of the shift path at frame start
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            frame_word <= '0;
        end else if (!frame_sys && i_data_valid) begin
            frame_word <= i_data_word;
        end
    end

    // Busy flag for the producer of the word
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_frame_busy <= 1'b0;
        end else begin
            o_frame_busy <= frame_sys;
        end
    end

    // Rising edge counter; chip select high ends the frame, since the
    // host clock may stop before any further edge
    // Saturation keeps a very long frame on the chain or zero tail
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            rise_cnt <= '0;
        end else if (rise_cnt != CNT_MAX) begin
            rise_cnt <= rise_cnt + 6'h01;
        end
    end

    // Falling edge counter
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            fall_cnt <= '0;
        end else if (fall_cnt != CNT_MAX) begin
            fall_cnt <= fall_cnt + 6'h01;
        end
    end

    // Chain input taken on rising edges
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            rise_chain <= '0;
        end else begin
            rise_chain <= {rise_chain[WORD_W-2:0], i_sdi};
        end
    end

    // Chain input taken on falling edges
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            fall_chain <= '0;
        end else begin
            fall_chain <= {fall_chain[WORD_W-2:0], i_sdi};
        end
    end

    // Launch edge per protocol; early launch moves it onto the capture edge
    always_comb begin
        launch_idx = fall_cnt;
        idx_valid = 1'b1;
        unique case (cap_mode_t'(cap_sel))
            CAP_LOW_RISE: begin
                // First bit at frame start, then rising edges in early or source-synchronous launch, else falling edges
                launch_idx = (early_launch || source_sync_mode) ? rise_cnt : fall_cnt;
            end
            CAP_HIGH_FALL: begin
                // First bit at frame start, then rising edges, or falling edges in early launch outside source-synchronous mode
                launch_idx = (early_launch && !source_sync_mode) ? fall_cnt : rise_cnt;
            end
            CAP_LOW_FALL: begin
                // Outside source-synchronous mode nothing is valid until the first rising edge
                launch_idx = source_sync_mode ? rise_cnt : rise_m1;
                idx_valid = source_sync_mode || (rise_cnt != '0);
            end
            CAP_HIGH_RISE: begin
                // Outside source-synchronous mode nothing is valid until the first falling edge
                launch_idx = source_sync_mode ? rise_cnt : fall_m1;
                idx_valid = source_sync_mode || (fall_cnt != '0);
            end
        endcase
    end

    // First word position of this launch: each launch carries one bit per lane
    wire [POS_W-1:0] base_pos = {3'h0, launch_idx} * {6'h00, lanes};

    // One selector per lane; past the word comes the chain or zeros
    // Only a single lane forwards the chain; wider buses pad zeros
    for (genvar j = 0; j < LANES_MAX; j++) begin : g_lane
        wire [POS_W-1:0] pos = base_pos + POS_W'(j);
        wire lane_on = !i_cs_n && idx_valid && (POS_W'(j) < POS_W'(lanes));
        wire in_word = (pos < POS_W'(WORD_W));
        wire tail = daisy_en && (lanes == LANES_ONE) && daisy_bit;
        assign lane_bit[j] = lane_on && (in_word ? frame_word[WORD_W - 1 - int'(pos)] : tail);
    end

    // Lanes face the host directly; a register here would add a clock of delay
    assign o_out_lane0 = lane_bit[0];
    assign o_out_lane1 = lane_bit[1];
    assign o_out_lane2 = lane_bit[2];
    assign o_out_lane3 = lane_bit[3];

    // Strobe echoes the host clock in source-synchronous mode, low otherwise
    assign o_strobe_out_pin = source_sync_mode && !i_cs_n && i_sclk;

    // Reset leaves mode zero in force
    reset_mode0_a: assert property (@(posedge i_sys_clk)
        !$past(i_resetn) |-> (cap_sel == CAP_LOW_RISE && output_protocol_sel == OUT_STANDARD))
        else $error("protocol not mode zero after reset");

    // Output configuration and word frozen through the frame
    frame_freeze_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (frame_sys && $past(frame_sys)) |-> ($stable(frame_word) && $stable(output_control_reg)))
        else $error("word or configuration moved inside a frame");

    // Strobe low in clocked protocols
    strobe_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !source_sync_mode |-> !o_strobe_out_pin)
        else $error("strobe high outside source-synchronous mode");

    // Strobe follows the host clock in source-synchronous mode; the value
    // sampled at a falling edge is the high phase that just ended
    strobe_clock_a: assert property (@(negedge i_sclk) disable iff (i_cs_n)
        source_sync_mode |-> o_strobe_out_pin)
        else $error("strobe not tracking clock");

    // Early launch refused with selectors 01 and 11
    early_refused_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (cap_sel == CAP_LOW_FALL || cap_sel == CAP_HIGH_RISE) |-> !early_launch)
        else $error("early launch active with late selector");

    // Early launch in mode zero steps on rising edges
    early_step_a: assert property (@(negedge i_sclk) disable iff (i_cs_n)
        (early_launch && cap_sel == CAP_LOW_RISE && !source_sync_mode) |-> launch_idx == rise_cnt)
        else $error("early launch not on capture edge");

    // First bit shown from the first rising edge in selector 01
    first_bit_a: assert property (@(negedge i_sclk) disable iff (i_cs_n)
        (cap_sel == CAP_LOW_FALL && !source_sync_mode && rise_cnt == 6'h01) |-> (idx_valid && base_pos == '0))
        else $error("first bit launched on wrong edge");

    // Dual lanes: eight launches cover sixteen bits
    dual_span_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        (lanes == LANES_TWO && idx_valid && launch_idx == 6'h08) |-> base_pos == 9'h010)
        else $error("dual lane position wrong");

    // Quad lanes: four launches cover sixteen bits
    quad_span_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        (lanes == LANES_FOUR && idx_valid && launch_idx == 6'h04) |-> base_pos == 9'h010)
        else $error("quad lane position wrong");

    // Single lane leaves the upper lanes quiet
    single_quiet_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        lanes == LANES_ONE |-> (lane_bit[3:1] == 3'h0))
        else $error("upper lanes driven in single lane mode");

    // Long frame without daisy chain pads zeros
    zero_pad_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        (!daisy_en && base_pos >= POS_W'(WORD_W)) |-> lane_bit == 4'h0)
        else $error("nonzero bits after the word");

    // Daisy chain forwards the delayed input
    daisy_out_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        (daisy_en && idx_valid && base_pos >= POS_W'(WORD_W)) |-> lane_bit[0] == daisy_bit)
        else $error("daisy chain bit not forwarded");

    // Busy flag trails the synchronised chip select by one edge
    busy_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        o_frame_busy == $past(frame_sys))
        else $error("busy flag not following chip select");

    // No lane driven outside a frame
    idle_lanes_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_cs_n |-> lane_bit == 4'h0)
        else $error("lane driven outside a frame");

    // Strobe quiet outside a frame in every protocol
    strobe_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_cs_n |-> !o_strobe_out_pin)
        else $error("strobe high outside a frame");

    // Word offered between frames is the one loaded
    word_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        ($past(i_resetn) && !$past(frame_sys) && $past(i_data_valid)) |-> frame_word == $past(i_data_word))
        else $error("offered word not loaded");

    // Input control value taken between frames
    config_take_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        ($past(i_resetn) && !$past(frame_sys)) |-> (input_control_reg == $past(i_input_control_reg)))
        else $error("capture selector not taken");

    // Capture selector frozen through the frame
    config_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (frame_sys && $past(frame_sys)) |-> $stable(input_control_reg))
        else $error("capture selector moved inside a frame");

    // Width codes other than dual and quad keep one lane
    lane_default_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (output_lane_width != LANE_DUAL && output_lane_width != LANE_QUAD) |-> lanes == LANES_ONE)
        else $error("lane count widened without a width code");

    // Dual lanes leave lanes two and three quiet
    dual_quiet_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        lanes == LANES_TWO |-> lane_bit[3:2] == 2'h0)
        else $error("upper lanes driven in dual lane mode");

    // Selector 01 shows nothing before the first rising edge
    wait_rise_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        (cap_sel == CAP_LOW_FALL && !source_sync_mode && rise_cnt == 6'h00) |-> lane_bit == 4'h0)
        else $error("bit shown before first rising edge");

    // Selector 11 shows nothing before the first falling edge
    wait_fall_a: assert property (@(negedge i_sclk) disable iff (i_cs_n)
        (cap_sel == CAP_HIGH_RISE && !source_sync_mode && fall_cnt == 6'h00) |-> lane_bit == 4'h0)
        else $error("bit shown before first falling edge");

    // Mode zero shows the top bit from the frame start
    mode0_first_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        (cap_sel == CAP_LOW_RISE && rise_cnt == 6'h00) |-> lane_bit[0] == frame_word[WORD_W-1])
        else $error("top bit missing at frame start");

    // Early launch with selector 10 steps on falling edges
    early_fall_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        (early_launch && cap_sel == CAP_HIGH_FALL && !source_sync_mode) |-> launch_idx == fall_cnt)
        else $error("early launch not on falling edge");

    // Standard mode zero steps on falling edges
    std_fall_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        (!early_launch && cap_sel == CAP_LOW_RISE && !source_sync_mode) |-> launch_idx == fall_cnt)
        else $error("standard launch not on falling edge");

    // Main scenarios
    cover_dual_frame: cover property (@(posedge i_sclk) lanes == LANES_TWO && launch_idx == 6'h08);
    cover_quad_frame: cover property (@(posedge i_sclk) lanes == LANES_FOUR && launch_idx == 6'h04);
    cover_early: cover property (@(posedge i_sclk) early_launch && rise_cnt == 6'h02);
    cover_daisy: cover property (@(posedge i_sclk) daisy_en && base_pos == 9'h017);
    cover_src: cover property (@(negedge i_sclk) source_sync_mode && o_strobe_out_pin);

endmodule : adc_serial_read_port

// ---- host_ctrl_model.sv ----
// Host side of the read port: makes chip select, the link clock and the
// upstream serial data, and captures the lanes as a real host would.
module host_ctrl_model (
    input wire logic i_out_lane0,
    input wire logic i_out_lane1,
    input wire logic i_out_lane2,
    input wire logic i_out_lane3,
    input wire logic i_strobe_out_pin,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam realtime HALF = 7.5; // Half period of the 15 ns link clock
    logic [3:0] lanes; // Lane bundle, lane0 as the top bit

    assign lanes = {i_out_lane0, i_out_lane1, i_out_lane2, i_out_lane3};

    // Quiet bus before the first frame
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end

    // One frame; clock stands at its idle level outside it
    task automatic frame(input logic [1:0] cap, input int nclk, input int nl, input logic [21:0] sdi_pat,
                         output logic [63:0] pre, output logic [63:0] post, output int strobe_hi);
        logic cap_first;
        cap_first = (cap == 2'h0) || (cap == 2'h2);
        pre = '0;
        post = '0;
        strobe_hi = 0;
        o_sclk = cap[1];
        #HALF;
        o_cs_n = 1'b0;
        #HALF;
        for (int i = 0; i < nclk; i++) begin
            o_sdi = (i < 22) ? sdi_pat[21 - i] : 1'b0;
            for (int e = 0; e < 2; e++) begin
                // Capture just before the edge; post sample shows early launch
                if ((e == 0) == cap_first) begin
                    pre = (pre << nl) | 64'(lanes >> (4 - nl));
                end
                o_sclk = ~o_sclk;
                #2;
                if ((e == 0) == cap_first) begin
                    post = {post[62:0], i_out_lane0};
                    if (i_strobe_out_pin) begin
                        strobe_hi++;
                    end
                end
                #(HALF - 2);
            end
        end
        o_cs_n = 1'b1;
        // Released data line must not keep its last value
        o_sdi = ~o_sdi;
    endtask : frame

endmodule : host_ctrl_model

// ---- testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import spi_read_pkg::*;

    logic sys_clk = 1'b0; // 40 MHz system clock
    logic resetn = 1'b0; // Active low reset
    logic sclk, cs_n, sdi; // Link side, driven by the host model
    logic [7:0] in_ctrl = 8'h00; // Capture protocol control
    logic [7:0] out_ctrl = 8'h00; // Output control
    logic [WORD_W-1:0] word = 22'h2A_5C3E; // Word under test
    logic data_valid = 1'b0; // Word load strobe
    logic lane0, lane1, lane2, lane3, strobe, busy; // Design outputs
    logic [21:0] sdi_pat = 22'h15_A0F3; // Upstream chain data
    logic [63:0] pre, post; // Captured streams
    int strobe_hi; // Strobe highs seen at capture
    int fails = 0;
    int samples_checked = 0;

    always #12.5 sys_clk = ~sys_clk;

    adc_serial_read_port u_adc_serial_read_port (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sdi(sdi), .i_input_control_reg(in_ctrl), .i_output_control_reg(out_ctrl),
        .i_data_word(word), .i_data_valid(data_valid), .o_out_lane0(lane0), .o_out_lane1(lane1),
        .o_out_lane2(lane2), .o_out_lane3(lane3), .o_strobe_out_pin(strobe), .o_frame_busy(busy));

    host_ctrl_model u_host_ctrl_model (.i_out_lane0(lane0), .i_out_lane1(lane1), .i_out_lane2(lane2),
        .i_out_lane3(lane3), .i_strobe_out_pin(strobe), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Config settles with chip select high, well clear of the sync delay
    task automatic run(input logic [7:0] ic, input logic [7:0] oc, input int nclk, input int nl);
        repeat (4) @(posedge sys_clk);
        #1;
        in_ctrl = ic;
        out_ctrl = oc;
        data_valid = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        data_valid = 1'b0;
        u_host_ctrl_model.frame(ic[1:0], nclk, nl, sdi_pat, pre, post, strobe_hi);
        #1;
        check("idle lanes", 64'({lane0, lane1, lane2, lane3}), 64'h0);
        check("busy tail", 64'(busy), 64'h1);
    endtask : run

    task automatic t_reset();
        check("reset outputs", 64'({lane0, lane3, strobe, busy}), 64'h0);
        run(8'h00, 8'h00, 22, 1);
        check("default read", 64'(pre[21:0]), 64'(word));
    endtask : t_reset

    // Every capture protocol, standard launch; output selector zero
    task automatic t_protocols();
        for (int c = 0; c < 4; c++) begin
            run(8'(c), 8'h00, 22, 1);
            check("legacy read", 64'(pre[21:0]), 64'(word));
            check("legacy strobe", 64'(strobe_hi), 64'h0);
            check("std post", 64'(post[21:1]), 64'(word[21:1]));
        end
    endtask : t_protocols

    // Early launch honoured only for capture selectors 00 and 10
    task automatic t_early();
        for (int c = 0; c < 4; c++) begin
            run(8'(c), 8'h01, 22, 1);
            check("early read", 64'(pre[21:0]), 64'(word));
            check("early post", 64'(post[21:1]), (c % 2 == 0) ? 64'(word[20:0]) : 64'(word[21:1]));
        end
    endtask : t_early

    // Wider buses and long frames that must pad with zeros
    task automatic t_lanes();
        run(8'h02, 8'h08, 14, 2);
        check("dual read", 64'(pre[27:0]), 64'({word, 6'h00}));
        run(8'h00, 8'h0C, 8, 4);
        check("quad read", 64'(pre[31:0]), 64'({word, 10'h000}));
        run(8'h01, 8'h04, 30, 1);
        check("single pad", 64'(pre[29:0]), 64'({word, 8'h00}));
    endtask : t_lanes

    // Long frames chain the upstream data behind the word
    task automatic t_daisy();
        run(8'h00, 8'h00, 44, 1);
        check("chain std", 64'(pre[43:0]), 64'({word, sdi_pat}));
        run(8'h02, 8'h01, 44, 1);
        check("chain early", 64'(pre[43:0]), 64'({word, sdi_pat}));
    endtask : t_daisy

    // Source synchronous: strobe echoes the link clock
    task automatic t_src();
        run(8'h00, 8'h03, 22, 1);
        check("src read", 64'(pre[21:0]), 64'(word));
        check("src strobe", 64'(strobe_hi), 64'd22);
    endtask : t_src

    task automatic test_done();
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    // Run takes about 9 us; the limit leaves a wide margin
    initial begin
        #100000;
        fails++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        t_reset();
        t_protocols();
        t_early();
        t_lanes();
        t_daisy();
        t_src();
        test_done();
    end

endmodule : testbench
